/* File: hw/eik_irq_top.sv */
// Top: external IRQ and keyboard merge logic with Avalon-MM registers
// What this block does
// - Interrupt pin is an asynchronous request source
// - Option picks edge-only or edge-plus-level sensing
// - Merge option ORs four keyboard lines in
// - Keyboard lines active on rising or high
// - Same sensing choice applies to keyboard lines
// - Status/control register sits at index 0x0d
// - Request recorded; cpu_irq_req forwards it only when enabled, irq_out follows the masked sticky events, the forwarded one set only when enabled
// - Enable rw, pending ro, clear bit writes
`default_nettype none
module eik_irq_top (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Pins
    input wire logic irq_pin_n,
    input wire logic [eik_pkg::EIK_KEY_N-1:0] keyboard_lines,
    // Avalon-MM slave
    input wire logic [eik_pkg::EIK_ADDR_W+1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // CPU request and system interrupt
    output logic cpu_irq_req,
    output logic irq_out
);
    import eik_pkg::*;

    // Reset release through two flops
    logic [1:0] rst_sync_r;
    logic rst_n;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // Pin synchronisers: first stage read only by second stage
    logic [EIK_KEY_N:0] pin_s1_r;
    logic [EIK_KEY_N:0] pin_s2_r;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            // Idle levels: pin high, keys low, so no false edge
            pin_s1_r <= {1'b1, {EIK_KEY_N{1'b0}}};
            pin_s2_r <= {1'b1, {EIK_KEY_N{1'b0}}};
        end else begin
            // Pin is async; no edge assumed at the pin itself
            pin_s1_r <= {irq_pin_n, keyboard_lines};
            pin_s2_r <= pin_s1_r;
        end
    end

    // Registers
    logic enable_r, enable_nxt;          // irq_enable_bit
    logic pend_r, pend_nxt;              // irq_pending_flag
    logic [1:0] opt_r, opt_nxt;          // mask_option_store
    logic [1:0] imask_r, imask_nxt;      // Interrupt mask
    logic [1:0] istat_r, istat_nxt;      // Sticky interrupt status
    logic cpu_req_r, cpu_req_nxt;
    logic irq_r, irq_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic wait_r, wait_nxt;              // Registered waitrequest
    eik_bus_e bus_r, bus_nxt;
    logic req_comb;
    logic wr_ok;
    logic [7:0] idx;
    logic [1:0] ev;

    // Sense block
    eik_sense_if sif ();
    eik_sense u_sense (
        .clk(core_clk),
        .rst_n(rst_n),
        .sif(sif)
    );

    // Combined active-high request: pin inverted, keys as-is
    always_comb begin
        req_comb = ~pin_s2_r[EIK_KEY_N];
        if (opt_r[EIK_MERGE_BIT]) begin
            // Keys active high, opposite to the pin
            req_comb = req_comb | (|pin_s2_r[EIK_KEY_N-1:0]);
        end
    end
    assign sif.req_line = req_comb;
    assign sif.level_mode = opt_r[EIK_LEVEL_BIT];

    // Address is a byte address: byte address is four times index
    assign idx = avs_address[EIK_ADDR_W+1:2];
    assign wr_ok = (bus_r == EIK_IDLE) & avs_write & avs_byteenable[0];

    // Next register values; hardware set wins over software clear
    always_comb begin
        enable_nxt = enable_r;
        opt_nxt = opt_r;
        imask_nxt = imask_r;
        pend_nxt = pend_r;
        istat_nxt = istat_r;
        if (wr_ok) begin
            unique case (idx)
                EIK_CTRL_IDX: begin
                    enable_nxt = avs_writedata[EIK_ENABLE_BIT];
                    if (avs_writedata[EIK_CLEAR_BIT]) begin
                        pend_nxt = 1'b0;
                    end
                end
                EIK_OPT_IDX: opt_nxt = avs_writedata[1:0];
                EIK_IMASK_IDX: imask_nxt = avs_writedata[1:0];
                EIK_ISTAT_IDX: istat_nxt = istat_r & ~avs_writedata[1:0];
                default: ;
            endcase
        end
        // Detection always recorded, regardless of enable
        if (sif.hit) begin
            pend_nxt = 1'b1;
        end
        ev = 2'b00;
        ev[EIK_EV_REQ_BIT] = sif.hit;
        ev[EIK_EV_FWD_BIT] = sif.hit & enable_r;
        istat_nxt = istat_nxt | ev;
        cpu_req_nxt = pend_nxt & enable_nxt;
        irq_nxt = |(istat_nxt & imask_nxt);
    end

    // Bus: one wait cycle, answer on second edge
    always_comb begin
        bus_nxt = bus_r;
        rdata_nxt = rdata_r;
        unique case (bus_r)
            EIK_IDLE: begin
                if (avs_read | avs_write) begin
                    bus_nxt = EIK_ACK;
                    rdata_nxt = 32'h0;
                    if (avs_read) begin
                        unique case (idx)
                            EIK_CTRL_IDX: begin
                                rdata_nxt[EIK_ENABLE_BIT] = enable_r;
                                rdata_nxt[EIK_PEND_BIT] = pend_r;
                            end
                            EIK_OPT_IDX: rdata_nxt[1:0] = opt_r;
                            EIK_IMASK_IDX: rdata_nxt[1:0] = imask_r;
                            EIK_ISTAT_IDX: rdata_nxt[1:0] = istat_r;
                            default: rdata_nxt = 32'h0;
                        endcase
                    end
                end
            end
            EIK_ACK: bus_nxt = EIK_IDLE;
        endcase
        // Low only in the answer cycle; kept in a flop for clean timing
        wait_nxt = ~(bus_nxt == EIK_ACK);
    end

    // State registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_r <= EIK_CTRL_RST[EIK_ENABLE_BIT];
            pend_r <= EIK_CTRL_RST[EIK_PEND_BIT];
            opt_r <= EIK_OPT_RST;
            imask_r <= EIK_IMASK_RST;
            istat_r <= 2'h0;
            cpu_req_r <= 1'b0;
            irq_r <= 1'b0;
            rdata_r <= 32'h0;
            wait_r <= 1'b1;
            bus_r <= EIK_IDLE;
        end else begin
            enable_r <= enable_nxt;
            pend_r <= pend_nxt;
            opt_r <= opt_nxt;
            imask_r <= imask_nxt;
            istat_r <= istat_nxt;
            cpu_req_r <= cpu_req_nxt;
            irq_r <= irq_nxt;
            rdata_r <= rdata_nxt;
            wait_r <= wait_nxt;
            bus_r <= bus_nxt;
        end
    end

    // Outputs straight from flops
    assign avs_readdata = rdata_r;
    assign avs_waitrequest = wait_r;
    assign cpu_irq_req = cpu_req_r;
    assign irq_out = irq_r;

    a_hit_pends: assert property (@(posedge core_clk)
        disable iff (!rst_n) sif.hit |=> pend_r)
        else $error("Hit did not set pending");
    a_fwd_gated: assert property (@(posedge core_clk)
        disable iff (!rst_n) cpu_irq_req |-> $past(enable_nxt))
        else $error("Request forwarded while disabled");
    a_clear_works: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        (wr_ok && idx == EIK_CTRL_IDX && avs_writedata[EIK_CLEAR_BIT]
        && !sif.hit) |=> !pend_r)
        else $error("Clear bit did not clear pending");
    a_key_merge: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        (!opt_r[EIK_MERGE_BIT] && pin_s2_r[EIK_KEY_N]) |-> !req_comb)
        else $error("Keys merged while option off");
    a_key_polar: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        (opt_r[EIK_MERGE_BIT] && pin_s2_r[0]) |-> req_comb)
        else $error("High key line not active");
    a_reg_answer: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        (bus_r == EIK_IDLE && (avs_read || avs_write)) |=> !avs_waitrequest)
        else $error("Bus answer not in one cycle");
    // No mask bit set and no mask write: the interrupt line stays low
    a_mask_gate: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        (imask_r == 2'h0 && !(wr_ok && idx == EIK_IMASK_IDX)) |=> !irq_out)
        else $error("Interrupt out while all masked");
    // Handshake steps: request taken while idle, one answer cycle
    sequence s_bus_take;
        bus_r == EIK_IDLE && (avs_read || avs_write);
    endsequence
    sequence s_bus_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    a_bus_cycle: assert property (@(posedge core_clk)
        disable iff (!rst_n) s_bus_take |=> s_bus_answer)
        else $error("Bus answer did not stand one cycle");
endmodule
`default_nettype wire

/* File: hw/eik_pkg.sv */
// Package: register map, field positions and reset values for the IRQ block
`default_nettype none
package eik_pkg;
    // Register word indices (byte address is four times the index)
    localparam int unsigned EIK_ADDR_W = 8;
    localparam logic [7:0] EIK_CTRL_IDX = 8'h0d;    // Status/control index
    localparam logic [7:0] EIK_OPT_IDX = 8'h20;     // Option store index
    localparam logic [7:0] EIK_IMASK_IDX = 8'h21;   // Interrupt mask index
    localparam logic [7:0] EIK_ISTAT_IDX = 8'h22;   // Sticky status index
    // Status/control bit positions
    localparam int unsigned EIK_ENABLE_BIT = 7;
    localparam int unsigned EIK_PEND_BIT = 3;
    localparam int unsigned EIK_CLEAR_BIT = 1;
    // Option store bit positions
    localparam int unsigned EIK_LEVEL_BIT = 0;
    localparam int unsigned EIK_MERGE_BIT = 1;
    // Sticky status bit positions
    localparam int unsigned EIK_EV_REQ_BIT = 0;
    localparam int unsigned EIK_EV_FWD_BIT = 1;
    // Reset values
    localparam logic [7:0] EIK_CTRL_RST = 8'h00;
    localparam logic [1:0] EIK_OPT_RST = 2'h0;
    localparam logic [1:0] EIK_IMASK_RST = 2'h0;
    // Number of keyboard lines
    localparam int unsigned EIK_KEY_N = 4;
    // Bus handshake states
    typedef enum logic [1:0] {EIK_IDLE, EIK_ACK} eik_bus_e;
endpackage
`default_nettype wire

/* File: hw/eik_sense.sv */
// Edge or edge-plus-level detector for the combined request line
`default_nettype none
module eik_sense (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Link to the top
    eik_sense_if.sense sif
);
    import eik_pkg::*;
    logic prev_r;   // Request line one cycle ago
    logic prev_nxt;
    logic hit_r;    // Registered sense result
    logic hit_nxt;

    // Next values: rising edge, or held level when level mode is on
    always_comb begin
        prev_nxt = sif.req_line;
        hit_nxt = (sif.req_line & ~prev_r) |
            (sif.level_mode & sif.req_line);
    end

    // Registers; line starts as idle, so a line already active when
    // reset lifts is taken as a fresh edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_r <= 1'b0;
            hit_r <= 1'b0;
        end else begin
            prev_r <= prev_nxt;
            hit_r <= hit_nxt;
        end
    end

    assign sif.hit = hit_r;

    a_edge_hit: assert property (@(posedge clk)
        disable iff (!rst_n) (sif.req_line && !prev_r) |=> sif.hit)
        else $error("Edge did not raise hit");
    a_no_idle_hit: assert property (@(posedge clk)
        disable iff (!rst_n) (!sif.req_line) |=> !sif.hit)
        else $error("Hit without active line");
endmodule
`default_nettype wire

/* File: hw/eik_sense_if.sv */
// Interface: synchronised request line between sense logic and top
`default_nettype none
interface eik_sense_if;
    logic level_mode;   // Edge plus level when high
    logic req_line;     // Combined active-high request, synchronised
    logic hit;          // Sense result: set pending this cycle
    modport top (output level_mode, output req_line, input hit);
    modport sense (input level_mode, input req_line, output hit);
endinterface
`default_nettype wire

/* File: verification/eik_src_model.sv */
// Model of the interrupt pin and the keyboard switches
`default_nettype none
module eik_src_model (
    // Clock
    input wire logic clk,
    // Requests from the bench
    input wire logic pin_low,
    input wire logic [3:0] key_hi,
    // Pins
    output logic irq_pin_n,
    output logic [3:0] keyboard_lines
);
    timeunit 1ns;
    timeprecision 1ns;
    // Pin idles high, keys idle low; both change after an edge
    always_ff @(posedge clk) begin
        irq_pin_n <= !pin_low;
        keyboard_lines <= key_hi;
    end
endmodule
`default_nettype wire

/* File: verification/tb.sv */
// Self-checking bench for the IRQ and keyboard block
`default_nettype none
`define CHK(g, e) chk(g, e)
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import eik_pkg::*;
    // Clock, reset and source requests
    logic core_clk = 0;
    logic resetn = 0;
    logic pin_low = 0;
    logic [3:0] key_hi = 4'h0;
    logic irq_pin_n;
    logic [3:0] keyboard_lines;
    // Avalon signals
    logic [9:0] avs_address = 10'h000;
    logic avs_read = 0;
    logic avs_write = 0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic [31:0] rd;
    logic avs_waitrequest;
    logic cpu_irq_req;
    logic irq_out;
    int fail_count = 0;
    int comparisons = 0;
    int cyc = 0;
    // Row: option, pin pulse, key pulse, pending expected
    typedef struct {logic [1:0] opt; logic pin; logic [3:0] key;
        logic exp;} eik_row_s;
    eik_row_s rows [6] = '{'{2'h0, 1, 4'h0, 1}, '{2'h0, 0, 4'h1, 0},
        '{2'h2, 0, 4'h2, 1}, '{2'h3, 0, 4'h4, 1},
        '{2'h1, 0, 4'h8, 0}, '{2'h1, 1, 4'h0, 1}};
    eik_src_model src (.clk(core_clk), .pin_low(pin_low),
        .key_hi(key_hi), .irq_pin_n(irq_pin_n),
        .keyboard_lines(keyboard_lines));
    eik_irq_top uut (.core_clk(core_clk), .resetn(resetn),
        .irq_pin_n(irq_pin_n), .keyboard_lines(keyboard_lines),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .cpu_irq_req(cpu_irq_req),
        .irq_out(irq_out));
    // Free-running clock
    initial begin
        forever #20 core_clk = !core_clk;
    end
    // Hang guard, far above the expected run length
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            end_sim();
        end
    end
    // Verdict
    task end_sim();
        $display("Mismatches %0d, checks %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Four-state compare, reports at once
    task chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask
    // One Avalon access; leading edge keeps strobes from double writes
    task bus(input logic we, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge core_clk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h0, wd};
        avs_read <= !we;
        avs_write <= we;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 0;
        avs_write <= 0;
    endtask
    task rd_chk(input logic [7:0] idx, input logic [7:0] e);
        bus(0, idx, 8'h00);
        `CHK(rd, {24'h0, e});
    endtask
    // Drive sources for n cycles, then release and let the sync settle
    task pulse(input logic p, input logic [3:0] k, input int n);
        @(posedge core_clk);
        pin_low <= p;
        key_hi <= k;
        repeat (n) @(posedge core_clk);
        pin_low <= 0;
        key_hi <= 4'h0;
        repeat (8) @(posedge core_clk);
    endtask
    // Hold a source active, clear pending meanwhile, read back
    task hold(input logic [1:0] o, input logic p, input logic [3:0] k,
        input logic [7:0] e);
        bus(1, EIK_OPT_IDX, {6'h0, o});
        pulse(p, k, 4);
        pin_low <= p;
        key_hi <= k;
        repeat (8) @(posedge core_clk);
        bus(1, EIK_CTRL_IDX, 8'h82);
        rd_chk(EIK_CTRL_IDX, e);
        pulse(0, 4'h0, 1);
    endtask
    // Main sequence
    initial begin
        repeat (8) @(posedge core_clk);
        resetn <= 1;
        repeat (3) @(posedge core_clk);
        `CHK(cpu_irq_req, 1'b0);
        rd_chk(EIK_CTRL_IDX, EIK_CTRL_RST);
        rd_chk(EIK_OPT_IDX, 8'h00);
        rd_chk(EIK_ISTAT_IDX, 8'h00);
        bus(1, 8'h05, 8'hff);
        rd_chk(8'h05, 8'h00);
        bus(1, EIK_CTRL_IDX, 8'h8a);
        rd_chk(EIK_CTRL_IDX, 8'h80);
        for (int i = 0; i < 6; i++) begin
            bus(1, EIK_OPT_IDX, {6'h0, rows[i].opt});
            bus(1, EIK_CTRL_IDX, 8'h82);
            pulse(rows[i].pin, rows[i].key, 4);
            rd_chk(EIK_CTRL_IDX, {4'h8, rows[i].exp, 3'h0});
            `CHK(cpu_irq_req, rows[i].exp);
        end
        hold(2'h1, 1, 4'h0, 8'h88);
        hold(2'h0, 1, 4'h0, 8'h80);
        hold(2'h3, 0, 4'hf, 8'h88);
        hold(2'h2, 0, 4'hf, 8'h80);
        // Request recorded while disabled, not forwarded
        bus(1, EIK_CTRL_IDX, 8'h02);
        bus(1, EIK_ISTAT_IDX, 8'h03);
        pulse(1, 4'h0, 4);
        rd_chk(EIK_CTRL_IDX, 8'h08);
        `CHK(cpu_irq_req, 1'b0);
        rd_chk(EIK_ISTAT_IDX, 8'h01);
        `CHK(irq_out, 1'b0);
        bus(1, EIK_IMASK_IDX, 8'h01);
        repeat (2) @(posedge core_clk);
        `CHK(irq_out, 1'b1);
        avs_byteenable <= 4'h0;
        bus(1, EIK_IMASK_IDX, 8'h00);
        avs_byteenable <= 4'hf;
        rd_chk(EIK_IMASK_IDX, 8'h01);
        bus(1, EIK_ISTAT_IDX, 8'h01);
        repeat (2) @(posedge core_clk);
        `CHK(irq_out, 1'b0);
        bus(1, EIK_CTRL_IDX, 8'h80);
        repeat (2) @(posedge core_clk);
        `CHK(cpu_irq_req, 1'b1);
        // Request while enabled marks both sticky events
        pulse(1, 4'h0, 4);
        rd_chk(EIK_ISTAT_IDX, 8'h03);
        end_sim();
    end
endmodule
`default_nettype wire
